// File: dv/result_rms_output_trigger_regs_asserts.sv
// Checker for the result, RMS and alert mask register bank
`timescale 1ns/1ns
module result_rms_output_trigger_regs_chk #(
  parameter RESULT_WIDTH = 12,
  parameter NUM_OUTPUTS = 5
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Results and RMS
  input wire ch7_result_valid,
  input wire [RESULT_WIDTH-1:0] ch7_result,
  input wire rms_sample_valid,
  input wire [3:0] rms_channel_select,
  input wire dc_removal_enable,
  input wire [1:0] rms_window_length,
  input wire rms_window_done,
  // Alerts
  input wire [7:0] alert_flags,
  input wire [NUM_OUTPUTS-1:0] output_update
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire [7:0] c7h = ch7_result[RESULT_WIDTH-1 -: 8];
  wire [7:0] c7l = {ch7_result[RESULT_WIDTH-9 -: 4], 4'h0};
  wire [7:0] wdl = reg_wdata & 8'hF7;
  // Shadow of output 0 mask, only this one is tracked to keep helper logic small
  reg [7:0] m0_reg;
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b) m0_reg <= 8'h02;
    else if (reg_wr && reg_addr == 8'hC3) m0_reg <= reg_wdata;
  wire hit0 = |(alert_flags & m0_reg);
  ////////////////////////////////////////
  a_ch7_high: assert property (ch7_result_valid ##1 (reg_rd && reg_addr == 8'hAF) |=> reg_rdata == $past(c7h, 2))
    else $error("ch7 high byte wrong");
  a_ch7_low: assert property (ch7_result_valid ##1 (reg_rd && reg_addr == 8'hAE) |=> reg_rdata == $past(c7l, 2))
    else $error("ch7 low byte wrong");
  a_rsvd_zero: assert property (reg_rd && reg_addr == 8'hC0 |=> reg_rdata[3] == 1'b0)
    else $error("reserved setup bit set");
  a_setup_copy: assert property (reg_wr && reg_addr == 8'hC0 |-> ##2
    {rms_channel_select, 1'b0, dc_removal_enable, rms_window_length} == $past(wdl, 2))
    else $error("setup fields wrong");
  a_mask_read: assert property (reg_rd && reg_addr == 8'hC3 |=> reg_rdata == $past(m0_reg))
    else $error("mask 0 readback wrong");
  a_alert_gate: assert property (output_update[0] == $past(hit0))
    else $error("output 0 update wrong");
  a_done_cause: assert property (rms_window_done |-> $past(rms_sample_valid) || $past(rms_sample_valid, 2))
    else $error("window done without sample");
  a_done_pulse: assert property (rms_window_done |=> !rms_window_done)
    else $error("window done too long");
  cover property (rms_window_done);
  cover property (reg_wr && reg_addr == 8'hC0);
  cover property (|output_update);
endmodule
bind result_rms_output_trigger_regs result_rms_output_trigger_regs_chk #(.RESULT_WIDTH(RESULT_WIDTH),
  .NUM_OUTPUTS(NUM_OUTPUTS)) i_chk (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ch7_result_valid, .ch7_result, .rms_sample_valid, .rms_channel_select, .dc_removal_enable,
  .rms_window_length, .rms_window_done, .alert_flags, .output_update);

// File: dv/result_rms_output_trigger_regs_tb.sv
// Self-checking bench for the result, RMS and alert mask register bank
`timescale 1ns/1ns
module result_rms_output_trigger_regs_tb;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, v6 = 0, v7 = 0, sv = 0, dce, done;
  logic [7:0] adr = 0, wd = 0, rdat, af = 0;
  logic [11:0] r6 = 0, r7 = 0;
  logic [15:0] rv = 0;
  logic [3:0] chs;
  logic [1:0] wl;
  logic [4:0] upd;
  integer miscompares = 0, num_checks = 0, cyc = 0, s = 0, c6 = 0, c7 = 0, rr = 0, dn = 0, i, j;
  integer m[5] = '{2, 1, 8, 4, 32};
  result_rms_output_trigger_regs i_result_rms_output_trigger_regs (.core_clk(clk), .rst_b(rst_b),
    .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .ch6_result_valid(v6),
    .ch6_result(r6), .ch7_result_valid(v7), .ch7_result(r7), .rms_sample_valid(sv), .rms_value(rv),
    .rms_channel_select(chs), .dc_removal_enable(dce), .rms_window_length(wl),
    .rms_window_done(done), .alert_flags(af), .output_update(upd));
  always #2 clk = ~clk;
  // Hang guard, the whole run needs about 2300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done) dn <= dn + 1;
    if (cyc > 20000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  task chk(string n, logic [7:0] seen, logic [7:0] e);
    num_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
    end
  endtask
  function integer ex(logic [7:0] a);
    case (a)
      8'hAD: ex = c6 >> 4;
      8'hAE: ex = (c7 & 15) << 4;
      8'hAF: ex = c7 >> 4;
      8'hC0: ex = s;
      8'hC1: ex = rr & 255;
      8'hC2: ex = rr >> 8;
      8'hC3, 8'hC5, 8'hC7, 8'hC9, 8'hCB: ex = m[(a - 8'hC3) / 2];
      default: ex = 0;
    endcase
  endfunction
  // One bus cycle; reads are compared with the model in the data cycle
  task acc(logic w, logic [7:0] a, logic [7:0] d);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    if (w && a == 8'hC0) s = d & 8'hF7;
    if (w && a >= 8'hC3 && a <= 8'hCB && a[0]) m[(a - 8'hC3) / 2] = d;
    if (!w) chk("rdata", rdat, 8'(ex(a)));
  endtask
  task tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h8D7C803F));
    repeat (16) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    #1;
    for (i = 8'hAC; i <= 8'hCC; i++) acc(0, 8'(i), 0);
    repeat (2) begin
      for (i = 8'hAC; i <= 8'hCC; i++) acc(1, 8'(i), 8'($urandom));
      for (i = 8'hAC; i <= 8'hCC; i++) acc(0, 8'(i), 0);
    end
    acc(1, 8'hC0, 8'($urandom));
    @(posedge clk);
    #1;
    chk("chan", 8'(chs), 8'(s >> 4));
    chk("dc", 8'(dce), 8'((s >> 2) & 1));
    chk("win", 8'(wl), 8'(s & 3));
    for (j = 0; j < 4; j++) begin
      r6 <= 12'($urandom);
      r7 <= 12'($urandom);
      v6 <= 1;
      v7 <= 1;
      @(posedge clk);
      v6 <= 0;
      v7 <= 0;
      c6 = r6;
      c7 = r7;
      acc(0, 8'(8'hAE + j % 2), 0);
      acc(0, 8'(8'hAF - j % 2), 0);
      acc(0, 8'hAD, 0);
    end
    repeat (40) begin
      af <= 8'($urandom);
      @(posedge clk);
      #1;
      for (j = 0; j < 5; j++) chk("update", 8'(upd[j]), 8'(|(af & 8'(m[j]))));
    end
    af <= 0;
    acc(1, 8'hC0, 8'h00);
    for (i = 1; i <= 1024; i++) begin
      rv <= 16'($urandom);
      sv <= 1;
      @(posedge clk);
      sv <= 0;
      if (i == 1024) rr = rv;
      if (i == 512) acc(0, 8'hC1, 0);
      else @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
    chk("done", 8'(dn), 8'h01);
    acc(0, 8'hC1, 0);
    acc(0, 8'hC2, 0);
    tally_and_finish;
  end
endmodule

// File: rtl/result_rms_output_trigger_regs.v
// Register bank for channel 6/7 results, RMS setup and result, and output alert masks
//
// Overview of operation
// RULE1: Each channel high byte returns the top eight bits of its latest result, MSB aligned.
// RULE2: Each channel low byte returns the next eight result bits of that same latest conversion; the 12-bit result gives four bits, then four zeros.
// Here only the channel 7 low byte is decoded; the channel 6 low byte is not and reads zero.
// RULE3: Channel 7 low byte sits at 0xAE and high byte at 0xAF, both read-only and zero after reset.
// RULE4: Setup bits 7 to 4 choose which analog channel feeds the RMS computation, zero after reset.
// RULE5: Setup bit 2 set asks the RMS engine to remove the DC component, clear keeps it.
// RULE6: Setup bits 1 to 0 pick a window of 1024, 4096, 16384 or 65536 samples.
// RULE7: Setup bit 3 is reserved and always reads zero.
// RULE8: The register at 0xC1 shows the low byte of the 16-bit RMS result, zero after reset.
// RULE9: The register at 0xC2 shows the high byte of the RMS result, zero after reset.
// RULE10: Each output has an eight-bit mask whose bit n admits alerts of channel pin n.
// RULE11: A mask bit of 0 keeps that channel pin's alerts from updating the output.
// RULE12: A mask bit of 1 lets that channel pin's alerts cause an event update of the output.
// RULE13: The masks for outputs 0 to 4 sit at 0xC3, 0xC5, 0xC7, 0xC9 and 0xCB and are read-write.
// RULE14: The masks reset to 0x02, 0x01, 0x08, 0x04 and 0x20 for outputs 0 to 4.
// RULE15: Both RMS result bytes update together once a full window is accumulated.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "result_rms_trig_defs.vh"

module result_rms_output_trigger_regs #(
  parameter RESULT_WIDTH = `RESULT_WIDTH,
  parameter NUM_OUTPUTS = 5
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Conversion results from the converter core
  input wire ch6_result_valid,
  input wire [RESULT_WIDTH-1:0] ch6_result,
  input wire ch7_result_valid,
  input wire [RESULT_WIDTH-1:0] ch7_result,
  // RMS engine interface
  input wire rms_sample_valid,
  input wire [15:0] rms_value,
  output reg [3:0] rms_channel_select,
  output reg dc_removal_enable,
  output reg [1:0] rms_window_length,
  output reg rms_window_done,
  // Alert flags per channel pin and event updates per output
  input wire [7:0] alert_flags,
  output reg [NUM_OUTPUTS-1:0] output_update
);

  ////////////////////////////////////////////////////////////////
  // Register state

  reg [15:0] ch6_aligned_reg;
  reg [15:0] ch7_aligned_reg;
  reg [7:0] setup_reg;
  reg [15:0] rms_result_reg;
  reg [16:0] sample_count_reg;
  reg [16:0] sample_count_next;
  reg [7:0] mask_reg [0:NUM_OUTPUTS-1];
  reg [7:0] read_next;
  reg [16:0] window_len;
  wire [15:0] ch6_aligned;
  wire [15:0] ch7_aligned;
  integer i;
  wire setup_wr_hit;
  wire window_end;
  wire [NUM_OUTPUTS-1:0] masked_hit;
  wire [NUM_OUTPUTS-1:0] mask_wr_hit;
  reg [15:0] rms_result_next;
  reg rms_window_done_next;
  reg [7:0] result_read;
  reg [7:0] rms_read;
  reg [7:0] mask_read;

  // Place a result at the top of a 16-bit word, low bits zero
  function [15:0] msb_align;
    input [RESULT_WIDTH-1:0] value;
    begin
      msb_align = {value, {(16 - RESULT_WIDTH){1'b0}}};
    end
  endfunction

  // Mask address for output n
  function [7:0] mask_addr;
    input integer n;
    begin
      mask_addr = `ADDR_MASK0 + n[6:0] * 8'h02;
    end
  endfunction

  // Reset value of mask n
  function [7:0] mask_reset;
    input integer n;
    begin
      case (n)
        0: mask_reset = `MASK0_RESET;
        1: mask_reset = `MASK1_RESET;
        2: mask_reset = `MASK2_RESET;
        3: mask_reset = `MASK3_RESET;
        4: mask_reset = `MASK4_RESET;
        default: mask_reset = 8'h00;
      endcase
    end
  endfunction

  // Pick one byte of a left-aligned 16-bit word
  function [7:0] result_byte;
    input [15:0] word;
    input high;
    begin
      if (high) begin
        result_byte = word[15:8];
      end else begin
        result_byte = word[7:0];
      end
    end
  endfunction

  // Write strobe aimed at one register address
  function write_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      write_hit = wr && (addr == target);
    end
  endfunction

  // Sample count of each window code
  function [16:0] window_samples;
    input [1:0] code;
    begin
      case (code)
        `WIN_1024: window_samples = `WIN_LEN_1024;
        `WIN_4096: window_samples = `WIN_LEN_4096;
        `WIN_16384: window_samples = `WIN_LEN_16384;
        default: window_samples = `WIN_LEN_65536;
      endcase
    end
  endfunction

  assign ch6_aligned = msb_align(ch6_result);
  assign ch7_aligned = msb_align(ch7_result);

  // Setup write is shared by the setup store and the window restart
  assign setup_wr_hit = write_hit(reg_wr, reg_addr, `ADDR_RMS_SETUP);

  // RULE6 window closes on the sample that reaches the selected count
  assign window_end = rms_sample_valid && ((sample_count_reg + 17'h00001) >= window_len);

  ////////////////////////////////////////////////////////////////
  // Latest conversion results

  // RULE1 RULE2 latch aligned result
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ch6_aligned_reg <= 16'h0000;
      ch7_aligned_reg <= 16'h0000;
    end else begin
      if (ch6_result_valid) begin
        ch6_aligned_reg <= ch6_aligned;
      end
      if (ch7_result_valid) begin
        ch7_aligned_reg <= ch7_aligned;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // RMS setup and window tracking

  // RULE6 window length decode
  always @* begin
    window_len = window_samples(setup_reg[`SETUP_WIN_HI:`SETUP_WIN_LO]);
  end

  // RULE15 window counter and result capture, next state
  // A setup write restarts the window so a mixed window is never reported
  always @* begin
    sample_count_next = sample_count_reg;
    rms_result_next = rms_result_reg;
    rms_window_done_next = 1'b0;
    if (setup_wr_hit) begin
      sample_count_next = 17'h00000;
    end else if (window_end) begin
      sample_count_next = 17'h00000;
      rms_result_next = rms_value;
      rms_window_done_next = 1'b1;
    end else if (rms_sample_valid) begin
      sample_count_next = sample_count_reg + 17'h00001;
    end
  end

  // RULE4 RULE5 RULE7 setup write
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_reg <= `SETUP_RESET;
    end else if (setup_wr_hit) begin
      // Reserved bit never stored, so it cannot leak into the engine
      setup_reg <= reg_wdata & `SETUP_WRITE_MASK;
    end
  end

  // RULE15 latch both bytes at window end
  // Both bytes share one register so a read never mixes two windows
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_count_reg <= 17'h00000;
      rms_result_reg <= 16'h0000;
      rms_window_done <= 1'b0;
    end else begin
      sample_count_reg <= sample_count_next;
      rms_result_reg <= rms_result_next;
      rms_window_done <= rms_window_done_next;
    end
  end

  // RULE4 RULE5 RULE6 drive engine controls
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rms_channel_select <= 4'h0;
      dc_removal_enable <= 1'b0;
      rms_window_length <= 2'h0;
    end else begin
      rms_channel_select <= setup_reg[`SETUP_CHAN_HI:`SETUP_CHAN_LO];
      dc_removal_enable <= setup_reg[`SETUP_DC_BIT];
      rms_window_length <= setup_reg[`SETUP_WIN_HI:`SETUP_WIN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output alert masks

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g = g + 1) begin : gen_mask
      // RULE13 mask write decode
      assign mask_wr_hit[g] = write_hit(reg_wr, reg_addr, mask_addr(g));
      // RULE13 RULE14 mask storage
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          mask_reg[g] <= mask_reset(g);
        end else if (mask_wr_hit[g]) begin
          mask_reg[g] <= reg_wdata;
        end
      end
      // RULE10 RULE11 RULE12 only admitted channel pins count
      assign masked_hit[g] = |(alert_flags & mask_reg[g]);
    end
  endgenerate

  // RULE10 RULE11 RULE12 registered event update, one bit per output
  // Level copy of the masked alerts; edge shaping belongs to the output stage
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_update <= {NUM_OUTPUTS{1'b0}};
    end else begin
      output_update <= masked_hit;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read path

  // RULE1 RULE2 RULE3 result bytes
  // Channel 6 low byte lives outside this slice and reads zero here
  always @* begin
    result_read = 8'h00;
    case (reg_addr)
      `ADDR_CH6_HIGH: begin
        result_read = result_byte(ch6_aligned_reg, 1'b1);
      end
      `ADDR_CH7_LOW: begin
        result_read = result_byte(ch7_aligned_reg, 1'b0);
      end
      `ADDR_CH7_HIGH: begin
        result_read = result_byte(ch7_aligned_reg, 1'b1);
      end
      default: begin
        result_read = 8'h00;
      end
    endcase
  end

  // RULE7 RULE8 RULE9 setup and RMS bytes
  always @* begin
    rms_read = 8'h00;
    case (reg_addr)
      `ADDR_RMS_SETUP: begin
        // Reserved bit forced low on read as well as on write
        rms_read = setup_reg & `SETUP_WRITE_MASK;
      end
      `ADDR_RMS_LOW: begin
        rms_read = result_byte(rms_result_reg, 1'b0);
      end
      `ADDR_RMS_HIGH: begin
        rms_read = result_byte(rms_result_reg, 1'b1);
      end
      default: begin
        rms_read = 8'h00;
      end
    endcase
  end

  // RULE13 mask readback
  always @* begin
    mask_read = 8'h00;
    for (i = 0; i < NUM_OUTPUTS; i = i + 1) begin
      if (reg_addr == mask_addr(i)) begin
        mask_read = mask_reg[i];
      end
    end
  end

  // The three address classes never overlap, so an OR merges them
  always @* begin
    read_next = result_read | rms_read | mask_read;
  end

  // Unmapped addresses and idle cycles read zero
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// File: rtl/result_rms_trig_defs.vh
// Offsets, field positions, reset values and sizes for the result, RMS and trigger register bank
`ifndef RESULT_RMS_TRIG_DEFS_VH
`define RESULT_RMS_TRIG_DEFS_VH

`define ADDR_CH6_HIGH 8'hAD
`define ADDR_CH7_LOW 8'hAE
`define ADDR_CH7_HIGH 8'hAF
`define ADDR_RMS_SETUP 8'hC0
`define ADDR_RMS_LOW 8'hC1
`define ADDR_RMS_HIGH 8'hC2
`define ADDR_MASK0 8'hC3
`define ADDR_MASK1 8'hC5
`define ADDR_MASK2 8'hC7
`define ADDR_MASK3 8'hC9
`define ADDR_MASK4 8'hCB

`define SETUP_CHAN_HI 7
`define SETUP_CHAN_LO 4
`define SETUP_RSVD_BIT 3
`define SETUP_DC_BIT 2
`define SETUP_WIN_HI 1
`define SETUP_WIN_LO 0
`define SETUP_WRITE_MASK 8'hF7
`define SETUP_RESET 8'h00

`define MASK0_RESET 8'h02
`define MASK1_RESET 8'h01
`define MASK2_RESET 8'h08
`define MASK3_RESET 8'h04
`define MASK4_RESET 8'h20

`define WIN_1024 2'h0
`define WIN_4096 2'h1
`define WIN_16384 2'h2
`define WIN_65536 2'h3
`define WIN_LEN_1024 17'h00400
`define WIN_LEN_4096 17'h01000
`define WIN_LEN_16384 17'h04000
`define WIN_LEN_65536 17'h10000

`define RESULT_WIDTH 12
`define RESULT_RESET 8'h00

`endif
